/* pkg/flash_cfg_pkg.sv */
`default_nettype none
package flash_cfg_pkg;
   // serial command opcodes
   localparam logic [7:0]  OP_WRITE_REGS   = 8'h01;
   localparam logic [7:0]  OP_READ_CFG     = 8'h35;
   localparam logic [7:0]  OP_READ_ANY     = 8'h65;
   localparam logic [7:0]  OP_WRITE_ANY    = 8'h71;
   // generic register addresses
   localparam logic [23:0] ADDR_CFG1_NV    = 24'h000002;
   localparam logic [23:0] ADDR_CFG1_V     = 24'h800002;
   localparam logic [23:0] ADDR_CFG2_NV    = 24'h000003;
   localparam logic [23:0] ADDR_CFG2_V     = 24'h800003;
   // field positions and masks
   localparam int          BIT_FREEZE      = 0;
   localparam int          BIT_QUAD        = 1;
   localparam int          BIT_LANE3_OR_RESET_PIN   = 5;
   localparam int          BIT_QPI         = 6;
   localparam logic [7:0]  MIRROR_MASK     = 8'h2c;
   localparam logic [7:0]  CFG1_V_RW_MASK  = 8'h03;
   localparam logic [7:0]  RESERVED_MASK   = 8'hd0;
   localparam logic [7:0]  BP_MASK         = 8'h1c;
   localparam logic [7:0]  CFG1_NV_DEFAULT = 8'h00;
   localparam logic [7:0]  CFG2_NV_DEFAULT = 8'h08;
   // frame counters
   localparam logic [2:0]  LAST_BIT        = 3'h7;
   localparam logic [1:0]  ADDR_LAST       = 2'h2;
   localparam logic [1:0]  WRR_LAST        = 2'h1;
   localparam logic [1:0]  WRR_STATUS      = 2'h0;

   typedef enum logic [4:0] {
      PH_OPCODE = 5'h01,
      PH_ADDR   = 5'h02,
      PH_WDATA  = 5'h04,
      PH_RDATA  = 5'h08,
      PH_DONE   = 5'h10
   } phase_e;

   typedef struct packed {
      logic [7:0] cfg1_v;
      logic [7:0] cfg1_nv;
      logic [7:0] cfg2_v;
      logic [7:0] cfg2_nv;
   } reg_image_s;

   typedef struct packed {
      logic [7:0]  opcode;
      logic [23:0] addr;
      logic [7:0]  data;
      logic [1:0]  idx;
   } write_evt_s;

   // bits still at their default may change, others stay
   function automatic logic [7:0] merge_once(input logic [7:0] cur, input logic [7:0] def,
                                             input logic [7:0] data);
      logic [7:0] open_bits;
      open_bits  = ~(cur ^ def);
      merge_once = (cur & ~open_bits) | (data & open_bits);
   endfunction : merge_once
endpackage : flash_cfg_pkg
`default_nettype wire

/* core/volatile_config_lock_register.sv */
// Operation
// - bits 5, 3, 2 mirror the one-time option bits continuously
// - lane width bit set selects four-bit data path, clear selects dual or serial
// - four-lane mode: protect pin is lane 2, lane 3 pin is reset when deselected
// - four-lane mode forces internal write protect inactive high
// - serial and dual reads still work; host need not drive lanes 2 and 3
// - four-wide protocol active refuses clearing the lane width bit
// - write-registers updates persistent and volatile lane width together
// - read-config, read-any and write-any commands reach this register
// - lock bit freezes protection bits, option bits and one-time area
// - frozen bits silently ignored by register writes, no error
// - locked one-time area program fails and sets program error
// - unlocked: protection bits, lock bit writable, one-time area programmable
// - lock clears only on power cycle or hardware reset
// - power-on lock value comes from persistent lock default bit
// - one write may set the lock and other fields together
// - lock never blocks write-disable, lane width default or lane width
// - second register persistent bits give defaults, change once, volatile copy rules
// - persistent lane width default loads the volatile lane width bit
`default_nettype none
module volatile_config_lock_register (
   input  wire logic       clk_i,                     // core clock
   input  wire logic       arst_n_i,                  // power-on reset
   input  wire logic       sck_i,                     // serial link clock
   input  wire logic       cs_n_i,                    // chip select pin
   input  wire logic       io0_i,                     // serial data in
   output logic            io1_o,                     // serial data out
   output logic            io1_oe_n_o,                // data out enable
   input  wire logic       wp_io2_i,                  // protect pin or lane 2
   input  wire logic       lane3_or_reset_pin_i,      // lane 3 or reset pin
   input  wire logic [7:0] persistent_config_one_i,   // stored config one
   input  wire logic [7:0] persistent_config_two_i,   // stored config two
   input  wire logic [7:0] volatile_status_one_i,     // current status
   input  wire logic       sw_reset_i,                // software reset pulse
   input  wire logic       otp_prog_req_i,            // one-time program pulse
   input  wire logic       otp_addr_in_area_i,        // address hits area
   output logic [7:0]      volatile_config_one_o,     // config one value
   output logic [7:0]      volatile_config_two_o,     // config two value
   output logic            wp_effective_o,            // internal protect level
   output logic            lane2_is_data_o,           // protect pin is data
   output logic            lane3_is_data_o,           // lane 3 pin is data
   output logic            hw_reset_o,                // pin reset active
   output logic            status_write_o,            // status write pulse
   output logic [7:0]      status_write_data_o,       // filtered status
   output logic            nv_write_o,                // persistent write pulse
   output logic            nv_write_sel_o,            // 0 cfg one, 1 cfg two
   output logic [7:0]      nv_write_data_o,           // persistent data
   output logic            otp_prog_go_o,             // program accepted
   output logic            program_error_set_o        // program error pulse
);

   // pin and toggle synchronisers
   logic        cs_s1, cs_s2, wp_s1, wp_s2, l3_s1, l3_s2;
   logic        evt_s1, evt_s2, evt_s3, ack_s1, ack_s2;

   // core state
   logic [7:0]  vcfg, next_vcfg;
   logic [7:0]  cfg2_v, next_cfg2_v;
   logic        por_load;
   flash_cfg_pkg::reg_image_s snap, next_snap;
   logic        snap_req, next_snap_req;
   logic        next_status_write, next_nv_write, next_nv_sel;
   logic [7:0]  next_status_data, next_nv_data;
   logic        next_otp_go, next_perr;

   // link state
   flash_cfg_pkg::phase_e phase, next_phase;
   logic [2:0]  bit_cnt, next_bit_cnt;
   logic [1:0]  byte_cnt, next_byte_cnt;
   logic [7:0]  shift, next_shift, opcode, next_opcode, rd_byte, next_rd_byte;
   logic [23:0] addr, next_addr;
   flash_cfg_pkg::write_evt_s evt, next_evt;
   flash_cfg_pkg::reg_image_s img, next_img;
   logic        evt_tgl, next_evt_tgl, ack_tgl, next_ack_tgl;
   logic        rq_s1, rq_s2;
   logic        frame_rst_n;
   logic [7:0]  byte_in;

   // decoded core terms
   logic        evt_go, four_wide_command_protocol, frozen, reload_cold, hw_reset_act;
   logic        is_wrr, is_write_any_register_cmd, cfg1_v_hit, cfg1_nv_hit;
   logic [7:0]  quad_word;
   flash_cfg_pkg::reg_image_s image;

   // lane width write filtered by four-wide protocol
   function automatic logic quad_keep(input logic data_bit, input logic qpi_on);
      quad_keep = data_bit | qpi_on;
   endfunction : quad_keep

   // persistent config one write image
   function automatic logic [7:0] cfg1_nv_next(input logic [7:0] nv, input logic [7:0] data,
                                               input logic lock, input logic quad_new);
      logic [7:0] otp;
      otp = lock ? nv : flash_cfg_pkg::merge_once(nv, flash_cfg_pkg::CFG1_NV_DEFAULT, data);
      cfg1_nv_next = (nv & ~flash_cfg_pkg::MIRROR_MASK) | (otp & flash_cfg_pkg::MIRROR_MASK);
      cfg1_nv_next[flash_cfg_pkg::BIT_QUAD] = quad_new;
   endfunction : cfg1_nv_next

   // register select for read-any
   function automatic logic [7:0] read_select(input flash_cfg_pkg::reg_image_s im, input logic [23:0] a);
      case (a)
         flash_cfg_pkg::ADDR_CFG1_NV: read_select = im.cfg1_nv;
         flash_cfg_pkg::ADDR_CFG1_V:  read_select = im.cfg1_v;
         flash_cfg_pkg::ADDR_CFG2_NV: read_select = im.cfg2_nv;
         flash_cfg_pkg::ADDR_CFG2_V:  read_select = im.cfg2_v;
         default:                     read_select = 8'h00;
      endcase
   endfunction : read_select

   // synchronisers into the core domain
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         {cs_s1, cs_s2, wp_s1, wp_s2, l3_s1, l3_s2} <= 6'h3f;
         {evt_s1, evt_s2, evt_s3, ack_s1, ack_s2} <= 5'h00;
      end
      else
      begin
         {cs_s1, cs_s2} <= {cs_n_i, cs_s1};
         {wp_s1, wp_s2} <= {wp_io2_i, wp_s1};
         {l3_s1, l3_s2} <= {lane3_or_reset_pin_i, l3_s1};
         {evt_s1, evt_s2, evt_s3} <= {evt_tgl, evt_s1, evt_s2};
         {ack_s1, ack_s2} <= {ack_tgl, ack_s1};
      end
   end

   // core decode
   assign evt_go       = evt_s2 ^ evt_s3;
   assign four_wide_command_protocol          = cfg2_v[flash_cfg_pkg::BIT_QPI];
   assign frozen       = vcfg[flash_cfg_pkg::BIT_FREEZE];
   assign is_wrr       = evt.opcode == flash_cfg_pkg::OP_WRITE_REGS;
   assign is_write_any_register_cmd      = evt.opcode == flash_cfg_pkg::OP_WRITE_ANY;
   assign cfg1_v_hit   = (is_wrr && evt.idx == flash_cfg_pkg::WRR_LAST) ||
                         (is_write_any_register_cmd && evt.addr == flash_cfg_pkg::ADDR_CFG1_V);
   assign cfg1_nv_hit  = (is_wrr && evt.idx == flash_cfg_pkg::WRR_LAST) ||
                         (is_write_any_register_cmd && evt.addr == flash_cfg_pkg::ADDR_CFG1_NV);
   assign hw_reset_act = cfg2_v[flash_cfg_pkg::BIT_LANE3_OR_RESET_PIN] && !l3_s2 &&
                         (!vcfg[flash_cfg_pkg::BIT_QUAD] || cs_s2);
   assign reload_cold  = por_load || hw_reset_act;
   assign image        = '{vcfg, persistent_config_one_i, cfg2_v, persistent_config_two_i};

   // lane width and lock update value
   always_comb
   begin
      quad_word = vcfg;
      quad_word[flash_cfg_pkg::BIT_QUAD]   = quad_keep(evt.data[flash_cfg_pkg::BIT_QUAD], four_wide_command_protocol);
      quad_word[flash_cfg_pkg::BIT_FREEZE] = frozen | evt.data[flash_cfg_pkg::BIT_FREEZE];
   end

   // core next-state
   always_comb
   begin
      next_vcfg         = (vcfg & flash_cfg_pkg::CFG1_V_RW_MASK) |
                          (persistent_config_one_i & flash_cfg_pkg::MIRROR_MASK);
      next_cfg2_v       = cfg2_v;
      next_status_write = 1'b0;
      next_status_data  = status_write_data_o;
      next_nv_write     = 1'b0;
      next_nv_sel       = nv_write_sel_o;
      next_nv_data      = nv_write_data_o;
      next_otp_go       = 1'b0;
      next_perr         = 1'b0;
      next_snap         = snap;
      next_snap_req     = snap_req;
      if (reload_cold)
      begin
         next_vcfg[flash_cfg_pkg::BIT_QUAD]   = persistent_config_one_i[flash_cfg_pkg::BIT_QUAD];
         next_vcfg[flash_cfg_pkg::BIT_FREEZE] = persistent_config_one_i[flash_cfg_pkg::BIT_FREEZE];
         next_cfg2_v = persistent_config_two_i;
      end
      else if (sw_reset_i)
      begin
         // lock survives software reset
         next_vcfg[flash_cfg_pkg::BIT_QUAD] = persistent_config_one_i[flash_cfg_pkg::BIT_QUAD];
         next_cfg2_v = persistent_config_two_i;
      end
      else if (evt_go)
      begin
         if (is_wrr && evt.idx == flash_cfg_pkg::WRR_STATUS)
         begin
            // frozen protection bits kept, write-disable passes
            next_status_write = 1'b1;
            next_status_data  = frozen ?
               (evt.data & ~flash_cfg_pkg::BP_MASK) | (volatile_status_one_i & flash_cfg_pkg::BP_MASK) :
               evt.data;
         end
         if (cfg1_v_hit)
         begin
            next_vcfg[flash_cfg_pkg::BIT_QUAD]   = quad_word[flash_cfg_pkg::BIT_QUAD];
            next_vcfg[flash_cfg_pkg::BIT_FREEZE] = quad_word[flash_cfg_pkg::BIT_FREEZE];
         end
         if (cfg1_nv_hit)
         begin
            next_nv_write = 1'b1;
            next_nv_sel   = 1'b0;
            next_nv_data  = cfg1_nv_next(persistent_config_one_i, evt.data, frozen,
                                         quad_word[flash_cfg_pkg::BIT_QUAD]);
         end
         if (is_write_any_register_cmd && evt.addr == flash_cfg_pkg::ADDR_CFG2_V)
         begin
            next_cfg2_v = evt.data;
         end
         if (is_write_any_register_cmd && evt.addr == flash_cfg_pkg::ADDR_CFG2_NV)
         begin
            next_nv_write = 1'b1;
            next_nv_sel   = 1'b1;
            next_nv_data  = flash_cfg_pkg::merge_once(persistent_config_two_i,
                                                      flash_cfg_pkg::CFG2_NV_DEFAULT, evt.data);
         end
      end
      // one-time area program gate
      if (otp_prog_req_i)
      begin
         next_perr   = frozen && otp_addr_in_area_i;
         next_otp_go = !(frozen && otp_addr_in_area_i);
      end
      // publish register image to the link side
      if (ack_s2 == snap_req && image != snap)
      begin
         next_snap     = image;
         next_snap_req = !snap_req;
      end
   end

   // core registers
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         vcfg                <= 8'h00;
         cfg2_v              <= 8'h00;
         por_load            <= 1'b1;
         snap                <= '0;
         snap_req            <= 1'b0;
         status_write_o      <= 1'b0;
         status_write_data_o <= 8'h00;
         nv_write_o          <= 1'b0;
         nv_write_sel_o      <= 1'b0;
         nv_write_data_o     <= 8'h00;
         otp_prog_go_o       <= 1'b0;
         program_error_set_o <= 1'b0;
         wp_effective_o      <= 1'b1;
         lane2_is_data_o     <= 1'b0;
         lane3_is_data_o     <= 1'b0;
         hw_reset_o          <= 1'b0;
      end
      else
      begin
         vcfg                <= next_vcfg;
         cfg2_v              <= next_cfg2_v;
         por_load            <= 1'b0;
         snap                <= next_snap;
         snap_req            <= next_snap_req;
         status_write_o      <= next_status_write;
         status_write_data_o <= next_status_data;
         nv_write_o          <= next_nv_write;
         nv_write_sel_o      <= next_nv_sel;
         nv_write_data_o     <= next_nv_data;
         otp_prog_go_o       <= next_otp_go;
         program_error_set_o <= next_perr;
         wp_effective_o      <= vcfg[flash_cfg_pkg::BIT_QUAD] | wp_s2;
         lane2_is_data_o     <= vcfg[flash_cfg_pkg::BIT_QUAD];
         lane3_is_data_o     <= vcfg[flash_cfg_pkg::BIT_QUAD] & !cs_s2;
         hw_reset_o          <= hw_reset_act;
      end
   end

   assign volatile_config_one_o = vcfg;
   assign volatile_config_two_o = cfg2_v;

   // link side: frame state cleared whenever select is high
   assign frame_rst_n = arst_n_i & ~cs_n_i;
   assign byte_in     = {shift[6:0], io0_i};

   // serial command sequencing, serial lanes only
   always_comb
   begin
      next_shift    = byte_in;
      next_bit_cnt  = 3'(bit_cnt + 3'h1);
      next_byte_cnt = byte_cnt;
      next_phase    = phase;
      next_opcode   = opcode;
      next_addr     = addr;
      next_rd_byte  = rd_byte;
      next_evt      = evt;
      next_evt_tgl  = evt_tgl;
      next_img      = img;
      next_ack_tgl  = ack_tgl;
      if (rq_s2 != ack_tgl)
      begin
         next_img     = snap;
         next_ack_tgl = rq_s2;
      end
      if (bit_cnt == flash_cfg_pkg::LAST_BIT)
      begin
         case (phase)
            flash_cfg_pkg::PH_OPCODE:
            begin
               next_opcode = byte_in;
               case (byte_in)
                  flash_cfg_pkg::OP_READ_CFG:
                  begin
                     next_phase   = flash_cfg_pkg::PH_RDATA;
                     next_rd_byte = img.cfg1_v;
                  end
                  flash_cfg_pkg::OP_READ_ANY,
                  flash_cfg_pkg::OP_WRITE_ANY: next_phase = flash_cfg_pkg::PH_ADDR;
                  flash_cfg_pkg::OP_WRITE_REGS: next_phase = flash_cfg_pkg::PH_WDATA;
                  default: next_phase = flash_cfg_pkg::PH_DONE;
               endcase
            end
            flash_cfg_pkg::PH_ADDR:
            begin
               next_addr     = {addr[15:0], byte_in};
               next_byte_cnt = 2'(byte_cnt + 2'h1);
               if (byte_cnt == flash_cfg_pkg::ADDR_LAST)
               begin
                  next_byte_cnt = 2'h0;
                  if (opcode == flash_cfg_pkg::OP_READ_ANY)
                  begin
                     next_phase   = flash_cfg_pkg::PH_RDATA;
                     next_rd_byte = read_select(img, {addr[15:0], byte_in});
                  end
                  else
                  begin
                     next_phase = flash_cfg_pkg::PH_WDATA;
                  end
               end
            end
            flash_cfg_pkg::PH_WDATA:
            begin
               next_evt      = '{opcode, addr, byte_in, byte_cnt};
               next_evt_tgl  = !evt_tgl;
               next_byte_cnt = 2'(byte_cnt + 2'h1);
               if (opcode == flash_cfg_pkg::OP_WRITE_ANY || byte_cnt == flash_cfg_pkg::WRR_LAST)
               begin
                  next_phase = flash_cfg_pkg::PH_DONE;
               end
            end
            flash_cfg_pkg::PH_RDATA: next_rd_byte = rd_byte;
            default: next_phase = flash_cfg_pkg::PH_DONE;
         endcase
      end
   end

   // frame registers
   always_ff @(posedge sck_i or negedge frame_rst_n)
   begin
      if (!frame_rst_n)
      begin
         phase    <= flash_cfg_pkg::PH_OPCODE;
         bit_cnt  <= 3'h0;
         byte_cnt <= 2'h0;
         shift    <= 8'h00;
         opcode   <= 8'h00;
         addr     <= 24'h000000;
         rd_byte  <= 8'h00;
      end
      else
      begin
         phase    <= next_phase;
         bit_cnt  <= next_bit_cnt;
         byte_cnt <= next_byte_cnt;
         shift    <= next_shift;
         opcode   <= next_opcode;
         addr     <= next_addr;
         rd_byte  <= next_rd_byte;
      end
   end

   // link registers that outlive a frame
   always_ff @(posedge sck_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         evt     <= '0;
         evt_tgl <= 1'b0;
         img     <= '0;
         ack_tgl <= 1'b0;
         rq_s1   <= 1'b0;
         rq_s2   <= 1'b0;
      end
      else
      begin
         evt     <= next_evt;
         evt_tgl <= next_evt_tgl;
         img     <= next_img;
         ack_tgl <= next_ack_tgl;
         rq_s1   <= snap_req;
         rq_s2   <= rq_s1;
      end
   end

   // read data launched on the falling edge
   always_ff @(negedge sck_i or negedge frame_rst_n)
   begin
      if (!frame_rst_n)
      begin
         io1_o      <= 1'b0;
         io1_oe_n_o <= 1'b1;
      end
      else
      begin
         io1_o      <= rd_byte[3'(flash_cfg_pkg::LAST_BIT - bit_cnt)];
         io1_oe_n_o <= phase != flash_cfg_pkg::PH_RDATA;
      end
   end

   // checks on the core domain
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);

   sequence s_wrr_cfg;
      evt_go && is_wrr && evt.idx == flash_cfg_pkg::WRR_LAST && !reload_cold && !sw_reset_i;
   endsequence

   a_mirror_track: assert property (
      $past(arst_n_i) |-> (vcfg & flash_cfg_pkg::MIRROR_MASK) ==
                          ($past(persistent_config_one_i) & flash_cfg_pkg::MIRROR_MASK))
      else $error("mirror bits do not follow option bits");
   a_reserved_zero: assert property (
      (volatile_config_one_o & flash_cfg_pkg::RESERVED_MASK) == 8'h00)
      else $error("reserved bits not zero");
   a_wp_forced: assert property (
      vcfg[flash_cfg_pkg::BIT_QUAD] |=> wp_effective_o)
      else $error("write protect not forced high");
   a_quad_kept: assert property (
      vcfg[flash_cfg_pkg::BIT_QUAD] && four_wide_command_protocol && !reload_cold && !sw_reset_i |=> vcfg[flash_cfg_pkg::BIT_QUAD])
      else $error("lane width cleared under four-wide protocol");
   a_wrr_both: assert property (
      s_wrr_cfg |=> nv_write_o && !nv_write_sel_o &&
                    nv_write_data_o[flash_cfg_pkg::BIT_QUAD] == vcfg[flash_cfg_pkg::BIT_QUAD])
      else $error("lane width copies differ after write-registers");
   a_bp_frozen: assert property (
      $past(frozen) && status_write_o |-> (status_write_data_o & flash_cfg_pkg::BP_MASK) ==
                                          ($past(volatile_status_one_i) & flash_cfg_pkg::BP_MASK))
      else $error("protection bits changed while locked");
   a_otp_fail: assert property (
      otp_prog_req_i && otp_addr_in_area_i && frozen |=> program_error_set_o && !otp_prog_go_o)
      else $error("locked one-time program not refused");
   a_otp_pass: assert property (
      otp_prog_req_i && !frozen |=> otp_prog_go_o && !program_error_set_o)
      else $error("unlocked one-time program refused");
   a_lock_sticky: assert property (
      frozen && !reload_cold |=> frozen [*1])
      else $error("lock cleared without hardware reset");
endmodule : volatile_config_lock_register
`default_nettype wire

/* tb/spi_host_model.sv */
`default_nettype none
module spi_host_model (
   output logic      sck_o,   // link clock, low outside frames
   output logic      cs_n_o,  // chip select
   output logic      io0_o,   // serial data to device
   input  wire logic io1_i    // serial data from device
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] rd_byte;
   // nonblocking so the deselect edge is seen at time zero
   initial
   begin
      sck_o  <= 1'b0;
      cs_n_o <= 1'b1;
      io0_o  <= 1'b0;
   end
   // serial frame only, mode 0, msb first: no quad commands issued
   task automatic cmd(input logic [39:0] v, input int n);
      cs_n_o = 1'b0;
      #20;
      for (int i = 0; i < n * 8; i++)
      begin
         io0_o = v[39-i];
         #15 sck_o = 1'b1;
         rd_byte = {rd_byte[6:0], io1_i};
         #15 sck_o = 1'b0;
      end
      #15 cs_n_o = 1'b1;
      io0_o = ~io0_o; // released line shows inverse
      #90;
   endtask : cmd
endmodule : spi_host_model
`default_nettype wire

/* tb/tb.sv */
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk_i = 0, arst_n_i = 1, wp = 0, l3 = 1, swr = 0, oreq = 0, ina = 1;
   logic [7:0] nv1 = 8'h2e, nv2 = 8'h08, vst = 8'h14, cfg1, cfg2, swd, nvd;
   logic       sck, cs_n, io0, io1, we, go, erp, l2, oen, l3d, hwr, nsel, swp, nvp;
   int         n_mismatch = 0, num_checks = 0, n_oe = 0, n_sw = 0, n_nv = 0;
   always #2.5 clk_i = ~clk_i;
   // read-enable sck edges and write pulses, counted where settled
   always @(posedge sck) n_oe += !oen;
   always @(negedge clk_i)
   begin
      n_sw += swp;
      n_nv += nvp;
   end
   spi_host_model host (.sck_o(sck), .cs_n_o(cs_n), .io0_o(io0), .io1_i(io1));
   volatile_config_lock_register uut (.clk_i(clk_i), .arst_n_i(arst_n_i),
      .sck_i(sck), .cs_n_i(cs_n), .io0_i(io0), .io1_o(io1), .io1_oe_n_o(oen),
      .wp_io2_i(wp), .lane3_or_reset_pin_i(l3), .persistent_config_one_i(nv1),
      .persistent_config_two_i(nv2), .volatile_status_one_i(vst),
      .sw_reset_i(swr), .otp_prog_req_i(oreq), .otp_addr_in_area_i(ina),
      .volatile_config_one_o(cfg1), .volatile_config_two_o(cfg2),
      .wp_effective_o(we), .lane2_is_data_o(l2), .lane3_is_data_o(l3d),
      .hw_reset_o(hwr), .status_write_o(swp), .status_write_data_o(swd),
      .nv_write_o(nvp), .nv_write_sel_o(nsel), .nv_write_data_o(nvd),
      .otp_prog_go_o(go), .program_error_set_o(erp));
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      num_checks++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task automatic wait_clk(input int n);
      repeat (n) @(negedge clk_i);
   endtask : wait_clk
   // cold reset, then settle
   task automatic t_por(input logic [7:0] e);
      arst_n_i <= 1'b0;
      wait_clk(20);
      arst_n_i = 1'b1;
      wait_clk(6);
      chk(cfg1, e);
   endtask : t_por
   // otp request over one edge, answer stands until the next
   task automatic t_otp(input logic g, input logic r);
      wait_clk(1);
      oreq = 1'b1;
      wait_clk(1);
      oreq = 1'b0;
      chk(go, g);
      chk(erp, r);
   endtask : t_otp
   task automatic t_read;
      host.cmd({8'h35, 32'h0}, 2);
      chk(host.rd_byte, 8'h2e);
      host.cmd({8'h65, 24'h800002, 8'h0}, 5);
      chk(host.rd_byte, 8'h2e);
      chk(l2, 1);
      chk(we, 1);
      chk(l3d, 0);
      chk(8'(n_oe), 8'h10);
   endtask : t_read
   task automatic t_wany;
      host.cmd({8'h71, 24'h800002, 8'hfc}, 5);
      chk(cfg1, 8'h2c);
      chk(we, 0);
      chk(l2, 0);
   endtask : t_wany
   task automatic t_wrr;
      t_otp(1, 0);
      host.cmd({8'h01, 8'h9c, 8'h03, 16'h0}, 3);
      chk(swd, 8'h9c);
      chk(cfg1, 8'h2f);
      chk(nvd, 8'h2e);
   endtask : t_wrr
   task automatic t_lock;
      host.cmd({8'h01, 8'h80, 8'h00, 16'h0}, 3);
      chk(swd, 8'h94);
      chk(cfg1, 8'h2d);
      chk(8'(n_sw), 8'h02);
      chk(8'(n_nv), 8'h02);
      chk(nsel, 0);
      t_otp(0, 1);
      ina = 1'b0;
      t_otp(1, 0);
      ina = 1'b1;
      swr = 1'b1;
      wait_clk(1);
      swr = 1'b0;
      wait_clk(4);
      chk(cfg1, 8'h2f);
   endtask : t_lock
   task automatic t_qpi;
      host.cmd({8'h71, 24'h800003, 8'h48}, 5);
      chk(cfg2, 8'h48);
      host.cmd({8'h71, 24'h800002, 8'h00}, 5);
      chk(cfg1, 8'h2f);
      host.cmd({8'h71, 24'h800003, 8'h28}, 5);
      wait_clk(1);
      l3 = 1'b0;
      wait_clk(3);
      chk(hwr, 1);
      wait_clk(7);
      l3 = 1'b1;
      wait_clk(6);
      chk(cfg1, 8'h2e);
      chk(cfg2, 8'h08);
      nv2 = 8'h48;
      host.cmd({8'h71, 24'h000003, 8'h00}, 5);
      chk(nvd, 8'h40);
      chk(nsel, 1);
      chk(8'(n_nv), 8'h03);
   endtask : t_qpi
   task automatic results;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : results
   // main sequence
   initial
   begin
      t_por(8'h2e);
      t_read;
      t_wany;
      t_wrr;
      t_lock;
      t_qpi;
      wait_clk(1);
      nv1 = 8'h2f;
      t_por(8'h2f);
      results;
   end
   // watchdog
   initial
   begin
      #100000;
      n_mismatch++;
      results;
   end
endmodule : tb
`default_nettype wire
